/* File: rtl/dsphp_top.sv */
// parallel host port with two bus styles, board id select, axi-lite view
//
// Functional notes
// RULE1 - port works only with serial select low
// RULE2 - never both control interfaces active together
// RULE3 - 8-bit address reaches every internal register
// RULE4 - 8 or 16 bit data, set by register
// RULE5 - host clock slower, below 100 mhz
// RULE6 - accesses sampled on host clock rising edge
// RULE7 - style pin: 0 separate, 1 single strobe
// RULE8 - host reads i, q and rssi words
// RULE9 - device drives data only for reads
// RULE10 - no access without port select low
// RULE11 - read/write strobes give type and validity
// RULE12 - ready low during access, high when done
// RULE13 - host holds select until ready high
// RULE14 - read data valid with ready handshake
// RULE15 - direction 1 read, 0 write; strobe marks
// RULE16 - ack low at completion, high on release
// RULE17 - single-strobe write acknowledged after some clocks
// RULE18 - single-strobe read acked with valid data
// RULE19 - four board id pins, sixteen identities
// RULE20 - compare programmed id with pins each access
// RULE21 - complete only on id match, else ignore
// RULE22 - ignored access drives no data, no handshake
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "dsphp_regs.svh"
module dsphp_top #(
  parameter logic [3:0] ACCESS_EDGES = `DSPHP_ACCESS_EDGES
) (
  input wire logic aclk,                 // system clock, 200 mhz
  input wire logic aresetn,              // sync reset, active low
  input wire logic [7:0] s_axi_awaddr,   // write address
  input wire logic s_axi_awvalid,        // write address valid
  output logic s_axi_awready,            // write address ready
  input wire logic [31:0] s_axi_wdata,   // write data
  input wire logic [3:0] s_axi_wstrb,    // byte enables
  input wire logic s_axi_wvalid,         // write data valid
  output logic s_axi_wready,             // write data ready
  output logic [1:0] s_axi_bresp,        // write response
  output logic s_axi_bvalid,             // write response valid
  input wire logic s_axi_bready,         // write response ready
  input wire logic [7:0] s_axi_araddr,   // read address
  input wire logic s_axi_arvalid,        // read address valid
  output logic s_axi_arready,            // read address ready
  output logic [31:0] s_axi_rdata,       // read data
  output logic [1:0] s_axi_rresp,        // read response
  output logic s_axi_rvalid,             // read data valid
  input wire logic s_axi_rready,         // read data ready
  input wire logic host_port_clock,      // clock made by the host
  input wire logic serial_select_pin,    // high selects serial control
  input wire logic style_pin,            // 0 separate, 1 single strobe
  input wire logic port_select_n,        // access in progress, low
  input wire logic wr_n_rw,              // write strobe or direction
  input wire logic rd_n_data_strobe_n,   // read strobe or data strobe
  input wire logic [3:0] board_device_id,// hardwired id pins
  input wire logic [7:0] host_addr,      // host address bus
  input wire logic [15:0] host_data_in,  // data bus level seen
  output logic [15:0] host_data_out,     // data bus drive value
  output logic [15:0] host_data_oe_n,    // data bus enable, low drives
  output logic handshake_out,            // ready or transfer_ack_n level
  output logic handshake_oe_n            // open drain enable, low drives
);

  localparam int PW = $bits(dsphp_pkg::dsphp_pins_t);

  dsphp_pkg::dsphp_pins_t pins_raw;
  dsphp_pkg::dsphp_pins_t pins;
  dsphp_pkg::dsphp_state_t state_r, state_nxt;
  logic [7:0] regs_r [0:255];
  logic hclk_d_r;
  logic [3:0] edge_cnt_r;
  logic is_read_r;
  logic [15:0] rd_word_r;
  logic [31:0] ctrl_r, win_addr_r, count_r;
  logic [15:0] out_i_r, out_q_r, out_rssi_r;
  logic [7:0] last_addr_r;
  logic last_ignored_r;
  logic [7:0] aw_addr_r, ar_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_have_r, w_have_r;

  logic hclk_rise, port_en, strobe_on, req_read, id_ok, wide, commit;
  logic do_write;

  assign pins_raw = '{clk: host_port_clock, serial_sel: serial_select_pin,
                      style: style_pin, cs_n: port_select_n,
                      wr_rw: wr_n_rw, rd_ds: rd_n_data_strobe_n,
                      id: board_device_id, addr: host_addr,
                      data: host_data_in};

  // every pin comes from the host domain
  dsphp_sync #(.W(PW)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_i(pins_raw),
    .sync_o(pins)
  );

  // read mux over register bytes and the output data words
  function automatic logic [7:0] host_byte(input logic [7:0] a);
    logic [7:0] b;
    b = regs_r[a];
    case (a)
      `DSPHP_OUT_I_ADDR: b = out_i_r[7:0]; // RULE8
      `DSPHP_OUT_I_ADDR + 8'h01: b = out_i_r[15:8];
      `DSPHP_OUT_Q_ADDR: b = out_q_r[7:0];
      `DSPHP_OUT_Q_ADDR + 8'h01: b = out_q_r[15:8];
      `DSPHP_OUT_RSSI_ADDR: b = out_rssi_r[7:0];
      `DSPHP_OUT_RSSI_ADDR + 8'h01: b = out_rssi_r[15:8];
      default: b = regs_r[a];
    endcase
    return b;
  endfunction : host_byte

  // host clock edge found from the synchronised level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hclk_d_r <= 1'b0;
    else
      hclk_d_r <= pins.clk;
  end

  assign hclk_rise = pins.clk & ~hclk_d_r; // RULE6
  // serial select high hands the pins to the serial port
  assign port_en = ~pins.serial_sel & ctrl_r[0]; // RULE1 RULE2
  // separate style needs exactly one strobe, single style the data strobe
  assign strobe_on = pins.style ? ~pins.rd_ds
                                : (pins.wr_rw ^ pins.rd_ds); // RULE7 RULE11
  assign req_read = pins.style ? pins.wr_rw : ~pins.rd_ds; // RULE15 RULE11
  assign id_ok = regs_r[`DSPHP_CIO_ADDR][`DSPHP_CIO_ID_MSB:`DSPHP_CIO_ID_LSB]
                 == pins.id; // RULE19 RULE20
  assign wide = regs_r[`DSPHP_CIO_ADDR][`DSPHP_CIO_WIDE_BIT]; // RULE4
  assign commit = (state_r == dsphp_pkg::ST_ACCESS) && hclk_rise
                  && (edge_cnt_r == ACCESS_EDGES - 4'h1);

  // sequencer; releasing select always ends the access
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      dsphp_pkg::ST_IDLE:
        if (hclk_rise && port_en && !pins.cs_n && strobe_on) // RULE10
          state_nxt = id_ok ? dsphp_pkg::ST_ACCESS
                            : dsphp_pkg::ST_IGNORE; // RULE21
      dsphp_pkg::ST_ACCESS:
        if (pins.cs_n)
          state_nxt = dsphp_pkg::ST_IDLE;
        else if (commit)
          state_nxt = dsphp_pkg::ST_DONE;
      dsphp_pkg::ST_DONE:
        // single style also releases when the data strobe rises
        if (pins.cs_n || (pins.style && pins.rd_ds)) // RULE16
          state_nxt = dsphp_pkg::ST_IDLE;
      dsphp_pkg::ST_IGNORE:
        if (pins.cs_n)
          state_nxt = dsphp_pkg::ST_IDLE;
      default: state_nxt = dsphp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_r <= dsphp_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // access length counted in host clock edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      edge_cnt_r <= 4'h0;
    else if (state_r != dsphp_pkg::ST_ACCESS)
      edge_cnt_r <= 4'h0;
    else if (hclk_rise)
      edge_cnt_r <= edge_cnt_r + 4'h1;
  end

  // access type and address caught when the access is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      is_read_r <= 1'b0;
      last_addr_r <= 8'h00;
      last_ignored_r <= 1'b0;
    end
    else if (state_r == dsphp_pkg::ST_IDLE
             && state_nxt != dsphp_pkg::ST_IDLE)
    begin
      is_read_r <= req_read;
      last_addr_r <= pins.addr;
      last_ignored_r <= ~id_ok;
    end
  end

  assign do_write = commit && !is_read_r;

  // register space, direct 8-bit addressing; 16-bit writes fill two bytes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 256; i++)
        regs_r[i] <= 8'h00;
      regs_r[`DSPHP_CIO_ADDR] <= `DSPHP_CIO_RESET;
    end
    else if (do_write)
    begin
      regs_r[last_addr_r] <= pins.data[7:0]; // RULE3 RULE4
      if (wide)
        regs_r[last_addr_r + 8'h01] <= pins.data[15:8];
    end
  end

  // read word latched at the completing edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_word_r <= 16'h0000;
    else if (commit && is_read_r)
      rd_word_r <= {wide ? host_byte(last_addr_r + 8'h01) : 8'h00,
                    host_byte(last_addr_r)}; // RULE8 RULE14 RULE18
  end

  // pin drivers; ignored accesses leave the shared bus alone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      host_data_out <= 16'h0000;
      host_data_oe_n <= 16'hffff;
      handshake_out <= 1'b0;
      handshake_oe_n <= 1'b1;
    end
    else
    begin
      handshake_out <= 1'b0;
      host_data_out <= rd_word_r;
      host_data_oe_n <= 16'hffff; // RULE22
      handshake_oe_n <= 1'b1; // RULE22
      if (state_r == dsphp_pkg::ST_ACCESS && !pins.style)
        handshake_oe_n <= 1'b0; // RULE12
      if (state_r == dsphp_pkg::ST_DONE)
      begin
        if (pins.style)
          handshake_oe_n <= 1'b0; // RULE16 RULE17
        if (is_read_r)
          host_data_oe_n <= wide ? 16'h0000 : 16'hff00; // RULE9 RULE4
      end
    end
  end

  // bus write side: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DSPHP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (aw_have_r && w_have_r && !s_axi_bvalid)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_r)
          `DSPHP_AXI_CTRL, `DSPHP_AXI_I, `DSPHP_AXI_Q, `DSPHP_AXI_RSSI,
          `DSPHP_AXI_WADDR: s_axi_bresp <= `DSPHP_RESP_OKAY;
          default: s_axi_bresp <= `DSPHP_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid
                       && !s_axi_bvalid;
      s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid
                      && !s_axi_bvalid;
    end
  end

  // software registers; strobes pick bytes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= `DSPHP_CTRL_RESET;
      out_i_r <= 16'h0000;
      out_q_r <= 16'h0000;
      out_rssi_r <= 16'h0000;
      win_addr_r <= 32'h0;
    end
    else if (aw_have_r && w_have_r && !s_axi_bvalid)
    begin
      for (int b = 0; b < 4; b++)
        if (w_strb_r[b])
          case (aw_addr_r)
            `DSPHP_AXI_CTRL: ctrl_r[b*8 +: 8] <= w_data_r[b*8 +: 8];
            `DSPHP_AXI_WADDR: win_addr_r[b*8 +: 8] <= w_data_r[b*8 +: 8];
            default: ;
          endcase
      if (w_strb_r[0])
        case (aw_addr_r)
          `DSPHP_AXI_I: out_i_r[7:0] <= w_data_r[7:0];
          `DSPHP_AXI_Q: out_q_r[7:0] <= w_data_r[7:0];
          `DSPHP_AXI_RSSI: out_rssi_r[7:0] <= w_data_r[7:0];
          default: ;
        endcase
      if (w_strb_r[1])
        case (aw_addr_r)
          `DSPHP_AXI_I: out_i_r[15:8] <= w_data_r[15:8];
          `DSPHP_AXI_Q: out_q_r[15:8] <= w_data_r[15:8];
          `DSPHP_AXI_RSSI: out_rssi_r[15:8] <= w_data_r[15:8];
          default: ;
        endcase
    end
  end

  // completed host accesses, useful for software polling
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_r <= 32'h0;
    else if (commit)
      count_r <= count_r + 32'h1;
  end

  // bus read side, answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DSPHP_RESP_OKAY;
      ar_addr_r <= 8'h00;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        ar_addr_r <= s_axi_araddr;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `DSPHP_RESP_OKAY;
        case (s_axi_araddr)
          `DSPHP_AXI_CTRL: s_axi_rdata <= ctrl_r;
          `DSPHP_AXI_STATUS: s_axi_rdata <= {15'h0, last_ignored_r,
                                            last_addr_r, pins.id, state_r};
          `DSPHP_AXI_I: s_axi_rdata <= {16'h0, out_i_r};
          `DSPHP_AXI_Q: s_axi_rdata <= {16'h0, out_q_r};
          `DSPHP_AXI_RSSI: s_axi_rdata <= {16'h0, out_rssi_r};
          `DSPHP_AXI_WADDR: s_axi_rdata <= win_addr_r;
          `DSPHP_AXI_WDATA: s_axi_rdata <= {24'h0, regs_r[win_addr_r[7:0]]};
          `DSPHP_AXI_COUNT: s_axi_rdata <= count_r;
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `DSPHP_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // checks next to the logic
  a_disabled_stays_idle: assert property ( // RULE1
    @(posedge aclk) disable iff (!aresetn)
    (state_r == dsphp_pkg::ST_IDLE && !port_en) |=>
      state_r == dsphp_pkg::ST_IDLE)
    else $error("port left idle while disabled");

  a_access_needs_id: assert property ( // RULE21
    @(posedge aclk) disable iff (!aresetn)
    $rose(state_r == dsphp_pkg::ST_ACCESS) |->
      $past(id_ok) && $past(!pins.cs_n))
    else $error("access taken without id match or select");

  a_ignore_silent: assert property ( // RULE22
    @(posedge aclk) disable iff (!aresetn)
    (state_r == dsphp_pkg::ST_IGNORE) ##1 (state_r == dsphp_pkg::ST_IGNORE)
      |-> host_data_oe_n == 16'hffff && handshake_oe_n)
    else $error("ignored access drove the bus");

  a_ready_low_busy: assert property ( // RULE12
    @(posedge aclk) disable iff (!aresetn)
    (state_r == dsphp_pkg::ST_ACCESS && !pins.style) |=>
      !handshake_oe_n && !handshake_out)
    else $error("ready not held low during access");

  a_ack_after_done: assert property ( // RULE16
    @(posedge aclk) disable iff (!aresetn)
    (state_r == dsphp_pkg::ST_ACCESS && pins.style) |=> handshake_oe_n)
    else $error("ack asserted before completion");

  a_access_bounded: assert property ( // RULE6
    @(posedge aclk) disable iff (!aresetn)
    $rose(state_r == dsphp_pkg::ST_ACCESS) |->
      ##[1:400] state_r != dsphp_pkg::ST_ACCESS)
    else $error("access never completed");

  a_write_lands: assert property ( // RULE3
    @(posedge aclk) disable iff (!aresetn)
    do_write |=> regs_r[last_addr_r] == $past(pins.data[7:0]))
    else $error("host write not stored");

  a_read_drives: assert property ( // RULE9
    @(posedge aclk) disable iff (!aresetn)
    (state_r == dsphp_pkg::ST_DONE && is_read_r) |=>
      !host_data_oe_n[0] && host_data_out == rd_word_r)
    else $error("read data not driven");

  a_write_no_drive: assert property ( // RULE9
    @(posedge aclk) disable iff (!aresetn)
    (state_r == dsphp_pkg::ST_DONE && !is_read_r) |=>
      host_data_oe_n == 16'hffff)
    else $error("bus driven during write");

endmodule : dsphp_top

/* File: rtl/dsphp_regs.svh */
// register offsets, field positions and timing counts of the host port
`ifndef DSPHP_REGS_SVH
`define DSPHP_REGS_SVH

// internal register space as seen from the host port pins
`define DSPHP_CIO_ADDR 8'h02
`define DSPHP_CIO_ID_LSB 0
`define DSPHP_CIO_ID_MSB 3
`define DSPHP_CIO_WIDE_BIT 4
`define DSPHP_CIO_RESET 8'h00
`define DSPHP_OUT_I_ADDR 8'hf8
`define DSPHP_OUT_Q_ADDR 8'hfa
`define DSPHP_OUT_RSSI_ADDR 8'hfc

// software register map on the bus
`define DSPHP_AXI_CTRL 8'h00
`define DSPHP_AXI_STATUS 8'h04
`define DSPHP_AXI_I 8'h08
`define DSPHP_AXI_Q 8'h0c
`define DSPHP_AXI_RSSI 8'h10
`define DSPHP_AXI_WADDR 8'h14
`define DSPHP_AXI_WDATA 8'h18
`define DSPHP_AXI_COUNT 8'h1c
`define DSPHP_CTRL_RESET 32'h0000_0001

// host clock edges spent on one internal access
`define DSPHP_ACCESS_EDGES 4'h2
`define DSPHP_RESP_OKAY 2'h0
`define DSPHP_RESP_SLVERR 2'h2

`endif

/* File: rtl/dsphp_pkg.sv */
// types shared by the host port modules
package dsphp_pkg;

  // one-hot port sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_ACCESS = 4'b0010,
    ST_DONE   = 4'b0100,
    ST_IGNORE = 4'b1000
  } dsphp_state_t;

  // host pins after synchronising
  typedef struct packed {
    logic clk;
    logic serial_sel;
    logic style;
    logic cs_n;
    logic wr_rw;
    logic rd_ds;
    logic [3:0] id;
    logic [7:0] addr;
    logic [15:0] data;
  } dsphp_pins_t;

endpackage : dsphp_pkg

/* File: rtl/dsphp_sync.sv */
// two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module dsphp_sync #(
  parameter int W = 1
) (
  input wire logic aclk,            // system clock
  input wire logic aresetn,         // sync reset, active low
  input wire logic [W-1:0] async_i, // pins from another domain
  output logic [W-1:0] sync_o       // second-stage outputs
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule : dsphp_sync

/* File: verif/dsphp_host.sv */
// programming host model: drives the port pins and resolves shared lines
`timescale 1ns/1ps
module dsphp_host (
  input wire logic aclk,                 // system clock, polling only
  output logic host_port_clock,          // host clock, runs in accesses
  output logic port_select_n,            // access select, low active
  output logic wr_n_rw,                  // write strobe or direction
  output logic rd_n_data_strobe_n,       // read strobe or data strobe
  output logic [7:0] host_addr,          // address bus
  output logic [15:0] host_data_in,      // resolved data bus level
  input wire logic [15:0] host_data_out, // device drive value
  input wire logic [15:0] host_data_oe_n,// device enable, low drives
  input wire logic handshake_out,        // device handshake value
  input wire logic handshake_oe_n        // device handshake enable
);
  logic run = 1'b0;
  logic drv = 1'b0;
  logic [15:0] hd = 16'h0000;
  logic [15:0] float_r = 16'h0000;
  logic hs;

  // pins idle at time zero
  initial
  begin
    port_select_n = 1'b1;
    wr_n_rw = 1'b1;
    rd_n_data_strobe_n = 1'b1;
    host_addr = 8'h00;
  end

  // clock stands still between accesses, as a host may leave it
  initial
  begin
    host_port_clock = 1'b0;
    forever
    begin
      #80;
      host_port_clock = run ? ~host_port_clock : 1'b0;
    end
  end

  // open drain handshake with pull-up; an undriven data line wanders
  assign hs = handshake_oe_n ? 1'b1 : handshake_out;
  assign host_data_in = (~host_data_oe_n & host_data_out) |
    (host_data_oe_n & (drv ? hd : float_r));
  always @(posedge aclk) float_r <= ~host_data_in;

  // one access in either style; ack stays 0 if never answered
  task automatic xfer(input logic st, input logic rd, input logic [7:0] a,
    input logic [15:0] wd, output logic [15:0] rv, output logic ack,
    output logic drove);
    logic low;
    int n;
    low = 1'b0;
    ack = 1'b0;
    drove = 1'b0;
    rv = 16'h0000;
    #1;
    host_addr = a;
    hd = wd;
    drv = ~rd;
    wr_n_rw = rd;
    rd_n_data_strobe_n = st ? 1'b0 : ~rd;
    run = 1'b1;
    #80;
    port_select_n = 1'b0;
    for (n = 0; n < 1200 && !ack; n++)
    begin
      @(posedge aclk);
      if (host_data_oe_n !== 16'hffff) drove = 1'b1;
      if (!hs) low = 1'b1;
      if (st ? !hs : (low && hs))
      begin
        ack = 1'b1;
        rv = host_data_in;
      end
    end
    // release off the sampling edge, never in the edge's own time step
    #1;
    port_select_n = 1'b1;
    wr_n_rw = 1'b1;
    rd_n_data_strobe_n = 1'b1;
    drv = 1'b0;
    for (n = 0; n < 200 && !hs; n++) @(posedge aclk);
    if (!hs) ack = 1'b0; // handshake must let go once select rises
    #640;
    run = 1'b0;
  endtask : xfer
endmodule : dsphp_host

/* File: verif/dsphp_top_tb.sv */
// self-checking bench: axi-lite register tasks and host port accesses
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end \
  end
module dsphp_top_tb;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic aclk, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, host_addr;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, board_device_id = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic serial_select_pin = 1'b0, style_pin = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, handshake_out, handshake_oe_n, host_port_clock;
  logic port_select_n, wr_n_rw, rd_n_data_strobe_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] host_data_in, host_data_out, host_data_oe_n;

  dsphp_top dsphp_top_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .host_port_clock, .serial_select_pin, .style_pin, .port_select_n,
    .wr_n_rw, .rd_n_data_strobe_n, .board_device_id, .host_addr,
    .host_data_in, .host_data_out, .host_data_oe_n, .handshake_out,
    .handshake_oe_n
  );

  dsphp_host dsphp_host_i (
    .aclk, .host_port_clock, .port_select_n, .wr_n_rw, .rd_n_data_strobe_n,
    .host_addr, .host_data_in, .host_data_out, .host_data_oe_n,
    .handshake_out, .handshake_oe_n
  );

  // 200 mhz system clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // verdict and end of run, shared by main sequence and timeout
  task automatic end_sim;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // cut a hang short well above the expected run length
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_total++;
      end_sim();
    end
  end

  // one write; both channels offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    r = 2'h3;
    // no cycle count assumed; only the bench timeout ends a wait
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  // one read, answer taken at the edge where rvalid is seen
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 2'h3;
    d = 32'h0;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    `CHK("axi rresp", er, r)
    `CHK("axi rdata", e, d & m)
  endtask : chk_rd

  // host access; a read is expected to drive the bus only when answered
  task automatic hx(input logic st, input logic rd, input logic [7:0] a,
    input logic [15:0] wd, input logic [15:0] m, input logic ea,
    input logic [15:0] er);
    logic [15:0] rv;
    logic ack;
    logic drove;
    @(posedge aclk);
    style_pin <= st;
    dsphp_host_i.xfer(st, rd, a, wd, rv, ack, drove);
    `CHK("host ack", ea, ack)
    `CHK("host drove", rd & ea, drove)
    if (rd & ea) `CHK("host rdata", er, rv & m)
  endtask : hx

  // main sequence
  initial
  begin
    logic [1:0] r;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd(8'h00, 32'hffffffff, 32'h1, 2'h0);
    chk_rd(8'h04, 32'h100ff, 32'h1, 2'h0);
    chk_rd(8'h20, 32'hffffffff, 32'h0, 2'h2);
    axi_wr(8'h04, 32'h0, r);
    `CHK("ro bresp", 2'h2, r)
    // 8-bit mode; cleared id field matches id pins at zero
    hx(0, 0, 8'h40, 16'h775a, 16'h0, 1, 16'h0);
    hx(0, 1, 8'h40, 16'h0, 16'h00ff, 1, 16'h5a);
    axi_wr(8'h14, 32'h40, r);
    chk_rd(8'h18, 32'hff, 32'h5a, 2'h0);
    axi_wr(8'h14, 32'h41, r);
    chk_rd(8'h18, 32'hff, 32'h0, 2'h0);
    // program id 3 and 16-bit width in single-strobe style
    hx(1, 0, 8'h02, 16'h0013, 16'h0, 1, 16'h0);
    @(posedge aclk);
    board_device_id <= 4'h3;
    hx(1, 0, 8'h20, 16'hbeef, 16'h0, 1, 16'h0);
    hx(1, 1, 8'h20, 16'h0, 16'hffff, 1, 16'hbeef);
    axi_wr(8'h14, 32'h21, r);
    chk_rd(8'h18, 32'hff, 32'hbe, 2'h0);
    // processed output words readable through the port
    for (int k = 0; k < 3; k++)
    begin
      axi_wr(8'h08 + 8'(4 * k), 32'h1111 * (k + 1), r);
      `CHK("word bresp", 2'h0, r)
      hx(0, 1, 8'hf8 + 8'(2 * k), 16'h0, 16'hffff, 1,
        16'(32'h1111 * (k + 1)));
    end
    // foreign id: silent, nothing written
    @(posedge aclk);
    board_device_id <= 4'h5;
    hx(0, 0, 8'h20, 16'h1234, 16'h0, 0, 16'h0);
    hx(1, 1, 8'h20, 16'h0, 16'h0, 0, 16'h0);
    chk_rd(8'h04, 32'h100f0, 32'h10050, 2'h0);
    @(posedge aclk);
    board_device_id <= 4'h3;
    hx(0, 1, 8'h20, 16'h0, 16'hffff, 1, 16'hbeef);
    // serial control owns the pins, then port disabled by software
    @(posedge aclk);
    serial_select_pin <= 1'b1;
    hx(0, 0, 8'h20, 16'h0, 16'h0, 0, 16'h0);
    @(posedge aclk);
    serial_select_pin <= 1'b0;
    axi_wr(8'h00, 32'h0, r);
    hx(1, 1, 8'h20, 16'h0, 16'h0, 0, 16'h0);
    axi_wr(8'h00, 32'h1, r);
    // nothing landed while serial control owned the pins
    hx(0, 1, 8'h20, 16'h0, 16'hffff, 1, 16'hbeef);
    chk_rd(8'h1c, 32'hffffffff, 32'ha, 2'h0);
    end_sim();
  end
endmodule : dsphp_top_tb
